// ### rtl/omcs_ctrl.sv
// Control and status logic of a pluggable optical module, with its two-wire management slave.
// Pins arrive asynchronous to mclk; serial clock is sampled, never used as a clock.
// Behaviour
// - Laser-off request rising turns laser off within 10 us.
// - Laser-off request falling restores modulated output within 1 ms.
// - Initialization, including fault clear, ends within 300 ms of power-on or release.
// - Laser fault output asserts within 1000 us of a fault.
// - Optical-loss output follows loss of input within 100 us both ways.
// - Software disable bit 6 of status byte acts within 100 ms of stop.
// - Fault status bit 2 sets within 100 ms of a fault.
// - Loss status bit 1 tracks signal loss within 100 ms.
// - Data-ready bit 0 asserts within 1000 ms of power-on.
// - Serial bus answers both device addresses within 300 ms of power-on.
// - Internal write completes within 40 ms, or 80 ms for five to eight bytes.
`timescale 1ns/100ps
`include "omcs_cfg.svh"

module omcs_ctrl #(
    parameter int INIT_CYC = `OMCS_INIT_CYC,
    parameter int DATA_READY_CYC = `OMCS_DATA_READY_CYC,
    parameter int WRITE_SHORT_CYC = `OMCS_WRITE_SHORT_CYC,
    parameter int WRITE_LONG_CYC = `OMCS_WRITE_LONG_CYC
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic laserOffReq,
    input wire logic laserFaultSense,
    input wire logic opticalLossSense,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    output logic laserEnable,
    output logic laserFault,
    output logic optical_loss_flag,
    output logic dataReady,
    output logic serialReady
);
    import omcs_pkg::*;

    initial begin
        if (INIT_CYC < 1 || DATA_READY_CYC < INIT_CYC || WRITE_SHORT_CYC < 1
            || WRITE_LONG_CYC < WRITE_SHORT_CYC || (WRITE_LONG_CYC | DATA_READY_CYC) >= (1 << 25))
            $error("omcs_ctrl: timing parameters out of range");
    end

    // Two-flop synchronisers; stage two and the edge history are the only readers
    logic [4:0] syncA, syncB, syncC;
    logic [4:0] next_syncA, next_syncB, next_syncC;
    logic offReq, faultSense, lossSense, scl, sda, sclPrev, sdaPrev;

    // Power-on timing and laser control
    logic [24:0] upCnt, next_upCnt;
    logic [7:0] holdCnt, next_holdCnt;
    logic faultLatch, next_faultLatch, swOff, next_swOff;
    logic next_laserEnable, next_laserFault, next_loss, next_dataReady, next_serialReady;

    // Serial slave
    omcs_state_t state, next_state;
    omcs_phase_t phase, next_phase;
    logic [7:0] shiftReg, next_shiftReg, ptr, next_ptr;
    logic [3:0] bitCnt, next_bitCnt, wrBytes, next_wrBytes;
    logic isDiag, next_isDiag, rdMode, next_rdMode, pendSw, next_pendSw;
    logic pendValid, next_pendValid, next_sdaOe;
    logic [24:0] busyCnt, next_busyCnt;
    logic sclRise, sclFall, startCond, stopCond;
    logic [7:0] statusByte, readByte;

    always_comb begin
        next_syncA = {laserOffReq, laserFaultSense, opticalLossSense, sclIn, sdaIn};
        next_syncB = syncA;
        next_syncC = syncB;
        {offReq, faultSense, lossSense, scl, sda} = syncB;
        sclPrev = syncC[1];
        sdaPrev = syncC[0];
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            syncA <= 5'h03;
            syncB <= 5'h03;
            syncC <= 5'h03;
        end else begin
            syncA <= next_syncA;
            syncB <= next_syncB;
            syncC <= next_syncC;
        end
    end

    always_comb begin
        sclRise = scl && !sclPrev;
        sclFall = !scl && sclPrev;
        startCond = scl && sclPrev && sdaPrev && !sda;
        stopCond = scl && sclPrev && !sdaPrev && sda;
        statusByte = 8'h00;
        statusByte[`OMCS_BIT_HW_OFF] = offReq;
        statusByte[`OMCS_BIT_SW_OFF] = swOff;
        statusByte[`OMCS_BIT_FAULT] = faultLatch;
        statusByte[`OMCS_BIT_LOSS] = lossSense;
        statusByte[`OMCS_BIT_READY] = dataReady;
        // Identity memory lives outside this block, so other bytes read as zero
        readByte = (isDiag && ptr == `OMCS_STATUS_BYTE) ? statusByte : 8'h00;
    end

    always_comb begin
        next_upCnt = (upCnt < 25'(DATA_READY_CYC)) ? upCnt + 25'h0000001 : upCnt;
        next_serialReady = (upCnt >= 25'(INIT_CYC));
        next_dataReady = (upCnt >= 25'(DATA_READY_CYC));
        next_holdCnt = holdCnt;
        if (!offReq)
            next_holdCnt = 8'h00;
        else if (holdCnt < 8'(`OMCS_RESET_HOLD_CYC))
            next_holdCnt = holdCnt + 8'h01;
        next_faultLatch = faultLatch;
        // Release after a long enough hold clears the shutdown; a live fault wins
        if (!offReq && syncC[4] && holdCnt >= 8'(`OMCS_RESET_HOLD_CYC))
            next_faultLatch = 1'b0;
        if (faultSense)
            next_faultLatch = 1'b1;
        next_laserFault = next_faultLatch;
        next_loss = lossSense;
        // Any disable source forces the laser off the cycle after it is seen
        next_laserEnable = next_serialReady && !offReq && !swOff && !next_faultLatch;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            upCnt <= 25'h0000000;
            holdCnt <= 8'h00;
            faultLatch <= 1'b0;
            laserEnable <= 1'b0;
            laserFault <= 1'b0;
            optical_loss_flag <= 1'b0;
            dataReady <= 1'b0;
            serialReady <= 1'b0;
        end else begin
            upCnt <= next_upCnt;
            holdCnt <= next_holdCnt;
            faultLatch <= next_faultLatch;
            laserEnable <= next_laserEnable;
            laserFault <= next_laserFault;
            optical_loss_flag <= next_loss;
            dataReady <= next_dataReady;
            serialReady <= next_serialReady;
        end
    end

    always_comb begin
        next_state = state;
        next_phase = phase;
        next_shiftReg = shiftReg;
        next_ptr = ptr;
        next_bitCnt = bitCnt;
        next_wrBytes = wrBytes;
        next_isDiag = isDiag;
        next_rdMode = rdMode;
        next_pendSw = pendSw;
        next_pendValid = pendValid;
        next_sdaOe = sdaOe;
        next_swOff = swOff;
        next_busyCnt = (busyCnt != 25'h0000000) ? busyCnt - 25'h0000001 : busyCnt;
        if (startCond) begin
            next_state = OMCS_RECV;
            next_phase = OMCS_PH_DEV;
            next_bitCnt = 4'h0;
            next_sdaOe = 1'b0;
        end else if (stopCond) begin
            next_state = OMCS_IDLE;
            next_sdaOe = 1'b0;
            if (pendValid)
                next_swOff = pendSw;
            if (wrBytes != 4'h0) begin
                // Write cycle: the slave refuses its address until the cycle ends
                if (wrBytes <= `OMCS_SHORT_WRITE_BYTES)
                    next_busyCnt = 25'(WRITE_SHORT_CYC);
                else
                    next_busyCnt = 25'(WRITE_LONG_CYC);
            end
            next_wrBytes = 4'h0;
            next_pendValid = 1'b0;
        end else begin
            case (state)
                OMCS_IDLE: begin
                    next_sdaOe = 1'b0;
                end
                OMCS_RECV: begin
                    if (sclRise) begin
                        next_shiftReg = {shiftReg[6:0], sda};
                        next_bitCnt = bitCnt + 4'h1;
                    end else if (sclFall && bitCnt == 4'h8) begin
                        next_bitCnt = 4'h0;
                        next_state = OMCS_ACK;
                        next_sdaOe = 1'b1;
                        case (phase)
                            OMCS_PH_DEV: begin
                                next_isDiag = (shiftReg[7:1] == `OMCS_DEV_DIAG_ADDR);
                                next_rdMode = shiftReg[0];
                                if (!serialReady || busyCnt != 25'h0000000
                                    || (shiftReg[7:1] != `OMCS_DEV_ID_ADDR
                                    && shiftReg[7:1] != `OMCS_DEV_DIAG_ADDR)) begin
                                    next_state = OMCS_IDLE;
                                    next_sdaOe = 1'b0;
                                end
                            end
                            OMCS_PH_PTR: begin
                                next_ptr = shiftReg;
                            end
                            OMCS_PH_DATA: begin
                                if (isDiag && ptr == `OMCS_STATUS_BYTE) begin
                                    next_pendSw = shiftReg[`OMCS_BIT_SW_OFF];
                                    next_pendValid = 1'b1;
                                end
                                if (wrBytes < `OMCS_MAX_COUNT_BYTES)
                                    next_wrBytes = wrBytes + 4'h1;
                                next_ptr = ptr + 8'h01;
                            end
                            default: next_state = OMCS_IDLE;
                        endcase
                    end
                end
                OMCS_ACK: begin
                    if (sclFall) begin
                        next_sdaOe = 1'b0;
                        if (phase == OMCS_PH_DEV && rdMode) begin
                            next_state = OMCS_SEND;
                            next_shiftReg = {readByte[6:0], 1'b0};
                            next_sdaOe = !readByte[7];
                            next_bitCnt = 4'h1;
                        end else begin
                            next_state = OMCS_RECV;
                            next_phase = (phase == OMCS_PH_DEV) ? OMCS_PH_PTR : OMCS_PH_DATA;
                        end
                    end
                end
                OMCS_SEND: begin
                    if (sclFall) begin
                        if (bitCnt == 4'h8) begin
                            next_sdaOe = 1'b0;
                            next_state = OMCS_MACK;
                            next_ptr = ptr + 8'h01;
                        end else begin
                            next_sdaOe = !shiftReg[7];
                            next_shiftReg = {shiftReg[6:0], 1'b0};
                            next_bitCnt = bitCnt + 4'h1;
                        end
                    end
                end
                OMCS_MACK: begin
                    if (sclRise && sda)
                        next_state = OMCS_IDLE;
                    else if (sclFall) begin
                        next_state = OMCS_SEND;
                        next_shiftReg = {readByte[6:0], 1'b0};
                        next_sdaOe = !readByte[7];
                        next_bitCnt = 4'h1;
                    end
                end
                default: next_state = OMCS_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= OMCS_IDLE;
            phase <= OMCS_PH_DEV;
            shiftReg <= 8'h00;
            ptr <= 8'h00;
            bitCnt <= 4'h0;
            wrBytes <= 4'h0;
            isDiag <= 1'b0;
            rdMode <= 1'b0;
            pendSw <= 1'b0;
            pendValid <= 1'b0;
            sdaOe <= 1'b0;
            sdaOut <= 1'b0;
            swOff <= 1'b0;
            busyCnt <= 25'h0000000;
        end else begin
            state <= next_state;
            phase <= next_phase;
            shiftReg <= next_shiftReg;
            ptr <= next_ptr;
            bitCnt <= next_bitCnt;
            wrBytes <= next_wrBytes;
            isDiag <= next_isDiag;
            rdMode <= next_rdMode;
            pendSw <= next_pendSw;
            pendValid <= next_pendValid;
            sdaOe <= next_sdaOe;
            sdaOut <= 1'b0;
            swOff <= next_swOff;
            busyCnt <= next_busyCnt;
        end
    end
endmodule

// ### rtl/omcs_cfg.svh
// Timing and status-byte layout constants for the optical module control block.
// Assumes a 20 MHz mclk; every count is derived from the time as printed.
`ifndef OMCS_CFG_SVH
`define OMCS_CFG_SVH

`define OMCS_CLK_KHZ 20000
`define OMCS_RESET_HOLD_US 10
`define OMCS_RESET_HOLD_CYC ((`OMCS_RESET_HOLD_US * `OMCS_CLK_KHZ + 999) / 1000)
`define OMCS_INIT_MS 300
`define OMCS_INIT_CYC (`OMCS_INIT_MS * `OMCS_CLK_KHZ)
`define OMCS_DATA_READY_MS 1000
`define OMCS_DATA_READY_CYC (`OMCS_DATA_READY_MS * `OMCS_CLK_KHZ)
`define OMCS_WRITE_SHORT_MS 40
`define OMCS_WRITE_SHORT_CYC (`OMCS_WRITE_SHORT_MS * `OMCS_CLK_KHZ)
`define OMCS_WRITE_LONG_MS 80
`define OMCS_WRITE_LONG_CYC (`OMCS_WRITE_LONG_MS * `OMCS_CLK_KHZ)
`define OMCS_SHORT_WRITE_BYTES 4'h4
`define OMCS_MAX_COUNT_BYTES 4'h8

`define OMCS_DEV_ID_ADDR 7'h50
`define OMCS_DEV_DIAG_ADDR 7'h51
`define OMCS_STATUS_BYTE 8'h6E
`define OMCS_BIT_HW_OFF 7
`define OMCS_BIT_SW_OFF 6
`define OMCS_BIT_FAULT 2
`define OMCS_BIT_LOSS 1
`define OMCS_BIT_READY 0

`endif

// ### rtl/omcs_pkg.sv
// Types shared by the optical module control block.
// No dependencies.
package omcs_pkg;
    typedef enum logic [4:0] {
        OMCS_IDLE = 5'h01,
        OMCS_RECV = 5'h02,
        OMCS_ACK = 5'h04,
        OMCS_SEND = 5'h08,
        OMCS_MACK = 5'h10
    } omcs_state_t;

    typedef enum logic [1:0] {
        OMCS_PH_DEV = 2'h0,
        OMCS_PH_PTR = 2'h1,
        OMCS_PH_DATA = 2'h2
    } omcs_phase_t;
endpackage

// ### test/omcs_checker.sv
// Pin-level assertions for the optical module control block.
// Bound to omcs_ctrl; one mclk domain, idle while reset_n is low.
`timescale 1ns/100ps
module omcs_checker #(
    parameter int INIT_CYC = 20,
    parameter int DATA_READY_CYC = 40
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic laserOffReq,
    input wire logic laserFaultSense,
    input wire logic opticalLossSense,
    input wire logic sdaOe,
    input wire logic laserEnable,
    input wire logic laserFault,
    input wire logic optical_loss_flag,
    input wire logic dataReady,
    input wire logic serialReady
);
    logic [15:0] upCnt;
    logic [15:0] next_upCnt;
    logic [8:0] offCnt;
    logic [8:0] next_offCnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Saturating counts, so a long run never wraps into a false short hold
    always_comb begin
        next_upCnt = (upCnt == 16'hFFFF) ? upCnt : upCnt + 16'h1;
        next_offCnt = !laserOffReq ? 9'h0 : (offCnt == 9'h1FF) ? offCnt : offCnt + 9'h1;
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            upCnt <= '0;
            offCnt <= '0;
        end else begin
            upCnt <= next_upCnt;
            offCnt <= next_offCnt;
        end
    end
    sequence s_lossUp; ##[1:4] optical_loss_flag; endsequence
    sequence s_longHold; !laserFaultSense [*4] ##0 ($fell(laserOffReq) && offCnt > 9'hDC); endsequence
    property p_offFast; $rose(laserOffReq) |-> ##[1:4] !laserEnable; endproperty
    a_offFast: assert property (p_offFast) else $error("laser on after off request");
    property p_offHold; laserOffReq [*4] |-> !laserEnable; endproperty
    a_offHold: assert property (p_offHold) else $error("laser on while off held");
    property p_initOn; $rose(serialReady) && !laserOffReq && !laserFaultSense |-> ##[0:3] laserEnable; endproperty
    a_initOn: assert property (p_initOn) else $error("laser not on after init");
    property p_fault; $rose(laserFaultSense) |-> ##[1:4] laserFault; endproperty
    a_fault: assert property (p_fault) else $error("fault output late");
    property p_shortHold; $fell(laserOffReq) && offCnt < 9'hB4 && laserFault |-> ##4 laserFault; endproperty
    a_shortHold: assert property (p_shortHold) else $error("fault cleared by short pulse");
    property p_longHold; s_longHold |-> ##[1:4] !laserFault; endproperty
    a_longHold: assert property (p_longHold) else $error("fault kept after long pulse");
    property p_lossOn; $rose(opticalLossSense) |-> s_lossUp; endproperty
    a_lossOn: assert property (p_lossOn) else $error("loss flag late to set");
    property p_lossOff; $fell(opticalLossSense) |-> ##[1:4] !optical_loss_flag; endproperty
    a_lossOff: assert property (p_lossOff) else $error("loss flag late to clear");
    property p_ready; upCnt == DATA_READY_CYC + 3 |-> dataReady; endproperty
    a_ready: assert property (p_ready) else $error("data ready late");
    property p_serial; upCnt == INIT_CYC + 3 |-> serialReady; endproperty
    a_serial: assert property (p_serial) else $error("serial bus late");
    property p_quiet; !serialReady |-> !sdaOe; endproperty
    a_quiet: assert property (p_quiet) else $error("bus answered before ready");
endmodule

// ### test/omcs_host.sv
// Two-wire bus master standing in for the host board controller.
// SDA is open drain with a pull-up; SCL stays high outside frames.
`timescale 1ns/100ps
module omcs_host (
    input wire logic mclk,
    input wire logic sdaLine,
    output logic scl,
    output logic sdaDrv
);
    logic inFrame = 1'b0;
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic ph(input logic s, input logic d, input int n);
        @(posedge mclk);
        scl <= s;
        sdaDrv <= d;
        repeat (n - 1) @(posedge mclk);
    endtask
    // Eight mclk per bit, the clock ceiling time-scaled like the counts; data moves mid low phase
    // Each SCL phase lasts at least four mclk, the least the slave's sampling can follow
    task automatic xbit(input logic d, output logic q);
        ph(1'b0, sdaDrv, 2);
        ph(1'b0, d, 2);
        ph(1'b1, d, 4);
        @(negedge mclk);
        q = sdaLine;
    endtask
    task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] q,
        output logic ack);
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(last, ack);
    endtask
    task automatic xstart();
        if (inFrame) begin
            ph(1'b0, sdaDrv, 2);
            ph(1'b0, 1'b1, 2);
            ph(1'b1, 1'b1, 4);
        end
        ph(1'b1, 1'b0, 4);
        inFrame = 1'b1;
    endtask
    task automatic xstop();
        ph(1'b0, sdaDrv, 2);
        ph(1'b0, 1'b0, 2);
        ph(1'b1, 1'b0, 4);
        ph(1'b1, 1'b1, 1);
        inFrame = 1'b0;
        repeat (400) @(posedge mclk);
    endtask
endmodule

// ### test/test_optical_module_control_status.sv
// Self-checking bench for the optical module control block.
// Drives the pins and a two-wire master model; design counts other than the 10 us release hold are shortened.
`timescale 1ns/100ps
`include "omcs_cfg.svh"
module test_optical_module_control_status;
    localparam int INIT = 20;
    localparam int READY = 40;
    localparam int WSHORT = 600;
    localparam logic [7:0] DIAG_W = {`OMCS_DEV_DIAG_ADDR, 1'b0};
    logic mclk = 1'b0;
    logic reset_n, laserOffReq, laserFaultSense, opticalLossSense;
    logic sclIn, sdaDrv, sdaOut, sdaOe, sdaLine, ack;
    logic laserEnable, laserFault, optical_loss_flag, dataReady, serialReady;
    logic [7:0] q;
    int errors = 0;
    int comparisons = 0;
    // Row: laserOffReq, opticalLossSense, expected laserEnable, expected flag
    logic [3:0] rows [4] = '{4'h2, 4'h7, 4'h8, 4'hD};
    assign sdaLine = sdaOe ? sdaOut : sdaDrv;
    always #25 mclk = ~mclk;
    omcs_ctrl #(.INIT_CYC(INIT), .DATA_READY_CYC(READY), .WRITE_SHORT_CYC(WSHORT),
        .WRITE_LONG_CYC(2 * WSHORT)) i_omcs_ctrl (.mclk(mclk), .reset_n(reset_n),
        .laserOffReq(laserOffReq), .laserFaultSense(laserFaultSense),
        .opticalLossSense(opticalLossSense), .sclIn(sclIn), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .laserEnable(laserEnable), .laserFault(laserFault),
        .optical_loss_flag(optical_loss_flag), .dataReady(dataReady), .serialReady(serialReady));
    omcs_host i_omcs_host (.mclk(mclk), .sdaLine(sdaLine), .scl(sclIn), .sdaDrv(sdaDrv));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic settle();
        repeat (5) @(posedge mclk);
        @(negedge mclk);
    endtask
    task automatic sendb(input logic [7:0] b, input logic nack);
        i_omcs_host.xbyte(b, 1'b1, q, ack);
        chk("ack", {7'h0, nack}, {7'h0, ack});
    endtask
    task automatic pulse(input int n);
        @(posedge mclk);
        laserOffReq <= 1'b1;
        repeat (n) @(posedge mclk);
        laserOffReq <= 1'b0;
        settle();
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        reset_n = 1'b0;
        laserOffReq = 1'b0;
        laserFaultSense = 1'b0;
        opticalLossSense = 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (READY + 8) @(posedge mclk);
        @(negedge mclk);
        chk("serialReady", 8'h01, {7'h0, serialReady});
        chk("dataReady", 8'h01, {7'h0, dataReady});
        for (int r = 0; r < 4; r++) begin
            @(posedge mclk);
            laserOffReq <= rows[r][3];
            opticalLossSense <= rows[r][2];
            settle();
            chk("laserEnable", {7'h0, rows[r][1]}, {7'h0, laserEnable});
            chk("lossFlag", {7'h0, rows[r][0]}, {7'h0, optical_loss_flag});
        end
        @(posedge mclk);
        laserOffReq <= 1'b0;
        opticalLossSense <= 1'b0;
        i_omcs_host.xstart();
        sendb(8'hA4, 1'b1);
        i_omcs_host.xstop();
        i_omcs_host.xstart();
        sendb({`OMCS_DEV_ID_ADDR, 1'b0}, 1'b0);
        i_omcs_host.xstop();
        chk("laserEnable", 8'h01, {7'h0, laserEnable});
        // Soft disable write, then the write cycle must refuse the next address
        i_omcs_host.xstart();
        sendb(DIAG_W, 1'b0);
        sendb(`OMCS_STATUS_BYTE, 1'b0);
        sendb(8'h40, 1'b0);
        i_omcs_host.xstop();
        chk("laserEnable", 8'h00, {7'h0, laserEnable});
        i_omcs_host.xstart();
        sendb(DIAG_W, 1'b1);
        i_omcs_host.xstop();
        @(posedge mclk);
        laserFaultSense <= 1'b1;
        opticalLossSense <= 1'b1;
        settle();
        chk("laserFault", 8'h01, {7'h0, laserFault});
        @(posedge mclk);
        laserFaultSense <= 1'b0;
        i_omcs_host.xstart();
        sendb(DIAG_W, 1'b0);
        sendb(`OMCS_STATUS_BYTE, 1'b0);
        i_omcs_host.xstart();
        sendb(DIAG_W | 8'h01, 1'b0);
        i_omcs_host.xbyte(8'hFF, 1'b1, q, ack);
        chk("status", 8'h47, q);
        i_omcs_host.xstop();
        pulse(100);
        chk("laserFault", 8'h01, {7'h0, laserFault});
        pulse(240);
        chk("laserFault", 8'h00, {7'h0, laserFault});
        chk("laserEnable", 8'h00, {7'h0, laserEnable});
        i_omcs_host.xstart();
        sendb(DIAG_W, 1'b0);
        sendb(`OMCS_STATUS_BYTE, 1'b0);
        sendb(8'h00, 1'b0);
        i_omcs_host.xstop();
        chk("laserEnable", 8'h01, {7'h0, laserEnable});
        repeat (WSHORT) @(posedge mclk);
        // Five data bytes take the long write cycle, still busy past the short one
        i_omcs_host.xstart();
        sendb(DIAG_W, 1'b0);
        for (int i = 0; i < 6; i++) sendb(8'h00, 1'b0);
        i_omcs_host.xstop();
        repeat (WSHORT / 2) @(posedge mclk);
        i_omcs_host.xstart();
        sendb(DIAG_W, 1'b1);
        i_omcs_host.xstop();
        i_omcs_host.xstart();
        sendb(DIAG_W, 1'b0);
        i_omcs_host.xstop();
        // Mid-run reset: outputs drop at once and power-on timing starts again
        @(posedge mclk);
        reset_n <= 1'b0;
        @(negedge mclk);
        chk("lossFlag", 8'h00, {7'h0, optical_loss_flag});
        chk("serialReady", 8'h00, {7'h0, serialReady});
        chk("dataReady", 8'h00, {7'h0, dataReady});
        @(posedge mclk);
        reset_n <= 1'b1;
        repeat (INIT - 2) @(posedge mclk);
        @(negedge mclk);
        chk("serialReady", 8'h00, {7'h0, serialReady});
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk("serialReady", 8'h01, {7'h0, serialReady});
        chk("laserEnable", 8'h01, {7'h0, laserEnable});
        tally_and_finish();
    end
    // Whole sequence needs about 7000 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end
endmodule
bind omcs_ctrl omcs_checker #(.INIT_CYC(INIT_CYC), .DATA_READY_CYC(DATA_READY_CYC))
    i_omcs_checker (.mclk(mclk), .reset_n(reset_n), .laserOffReq(laserOffReq),
    .laserFaultSense(laserFaultSense), .opticalLossSense(opticalLossSense), .sdaOe(sdaOe),
    .laserEnable(laserEnable), .laserFault(laserFault), .optical_loss_flag(optical_loss_flag),
    .dataReady(dataReady), .serialReady(serialReady));
